// File: rtl/evt_consts.svh
// Constants of the event timer: register offsets, field positions, reset values
// Assumes inclusion by bare name from the timer design files
`ifndef EVT_CONSTS_SVH
`define EVT_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EVT_OFS_CNT 5'h00
`define EVT_OFS_CMPA 5'h04
`define EVT_OFS_CMPB 5'h08
`define EVT_OFS_CTL0 5'h0c
`define EVT_OFS_STAT 5'h10
`define EVT_OFS_CTL1 5'h14

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define EVT_CNT_RST 8'h00
`define EVT_CMP_RST 8'hff
`define EVT_CNT_MAX 8'hff
`define EVT_STAT_ONES 8'h10
`define EVT_CTL1_ONES 8'he0
`define EVT_RD_ZERO 32'h00000000
`define EVT_PRE_RST 7'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EVT_B_IEB 7
`define EVT_B_IEA 6
`define EVT_B_OVERFLOW_IRQ_ENABLE 5
`define EVT_F_CLR 4:3
`define EVT_F_CKS 2:0
`define EVT_B_FB 7
`define EVT_B_FA 6
`define EVT_B_OVF 5
`define EVT_F_OSB 3:2
`define EVT_F_OSA 1:0
`define EVT_F_EDGE 4:3
`define EVT_B_TRIGGER_ENABLE 2
`define EVT_B_ICKS 0
`define EVT_B_BE0 0

`endif

// File: rtl/evt_pkg.sv
// Types of the event timer: bus words, selector encodings
// Assumes nothing beyond a SystemVerilog compiler
package evt_pkg;
  typedef logic [4:0] evt_addr_t;
  typedef logic [7:0] evt_byte_t;
  typedef logic [31:0] evt_word_t;
  typedef enum logic [2:0] {
    EVT_CK_OFF0 = 3'h0, EVT_CK_INT1 = 3'h1, EVT_CK_INT2 = 3'h2, EVT_CK_INT3 = 3'h3,
    EVT_CK_OFF4 = 3'h4, EVT_CK_EXTR = 3'h5, EVT_CK_EXTF = 3'h6, EVT_CK_EXTB = 3'h7
  } evt_cks_t;
  typedef enum logic [1:0] {
    EVT_CLR_NONE = 2'h0, EVT_CLR_A = 2'h1, EVT_CLR_B = 2'h2, EVT_CLR_PIN = 2'h3
  } evt_clr_t;
  typedef enum logic [1:0] {
    EVT_OS_KEEP = 2'h0, EVT_OS_LOW = 2'h1, EVT_OS_HIGH = 2'h2, EVT_OS_TOG = 2'h3
  } evt_os_t;
  typedef enum logic [1:0] {
    EVT_EDGE_OFF = 2'h0, EVT_EDGE_RISE = 2'h1, EVT_EDGE_FALL = 2'h2, EVT_EDGE_BOTH = 2'h3
  } evt_edge_t;
endpackage

// File: rtl/evt_prescaler.sv
// Prescaler: one-cycle ticks at clock/4 up to clock/128
// Assumes core_clk and synchronous rst
`timescale 1ns/100ps
`include "evt_consts.svh"
module evt_prescaler (
  input wire logic core_clk,
  input wire logic rst,
  evt_tick_if.src ticks
);
  import evt_pkg::*;
  logic [6:0] preCount;

  // ----------------------------------------------------------------
  // Free divider
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      preCount <= `EVT_PRE_RST;
    end else begin
      preCount <= preCount + 7'h01;
    end
  end

  // Tick i marks the falling edge of clock/(4 << i)
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ticks.tick <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        ticks.tick[i] <= &(preCount | ~((7'h04 << i) - 7'h01));
      end
    end
  end
endmodule // evt_prescaler

// File: rtl/evt_tick_if.sv
// Prescaler tick bundle between divider and timer core
// Assumes one clock for both ends
`timescale 1ns/100ps
interface evt_tick_if;
  logic [5:0] tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

// File: rtl/evt_timer.sv
// Eight-bit event timer with two compares, wave output and Avalon-MM registers
// Assumes core_clk at 40 MHz, synchronous rst, asynchronous pins
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`include "evt_consts.svh"

// Behaviour
// - 8-bit up-counter, source from clock_select
// - Counter readable and writable at any time
// - Wrap past maximum sets overflow_flag
// - Counter resets to zero
// - Both compare registers RW, reset all ones
// - Equality with compare sets its match flag
// - No compare during write to that register
// - Bits 7,6,5 enable the three requests
// - clear_select: none, match A, B, pin rise
// - After pin clear, trigger_enable decides halting
// - clock_select 000 or 100 stops counting
// - Internal prescaled ticks phi/4 to phi/128
// - External pin: rising, falling or both edges
// - Count-stop halts counter when it clears
// - Trigger pin edge starts counting, selectable
// - Both matches drive wave_out_pin independently
// - Nine count sources in total
// - Per match: keep, low, high, toggle
// - wave_out_pin low after reset
// - Flag clears only after read-one, write-zero
// - Trigger mode: start on edge, halt on clear
module evt_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire evt_pkg::evt_addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire evt_pkg::evt_word_t avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output evt_pkg::evt_word_t avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_clock_pin,
  input wire logic ext_clear_pin,
  input wire logic trigger_pin,
  output logic wave_out_pin,
  output logic matchAIrq,
  output logic matchBIrq,
  output logic overflowIrq
);
  import evt_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic edgeHit(evt_edge_t sel, logic rise, logic fall);
    case (sel)
      EVT_EDGE_RISE: edgeHit = rise;
      EVT_EDGE_FALL: edgeHit = fall;
      EVT_EDGE_BOTH: edgeHit = rise | fall;
      default: edgeHit = 1'b0;
    endcase
  endfunction

  function automatic logic applyOs(evt_os_t os, logic cur);
    case (os)
      EVT_OS_LOW: applyOs = 1'b0;
      EVT_OS_HIGH: applyOs = 1'b1;
      EVT_OS_TOG: applyOs = ~cur;
      default: applyOs = cur;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  evt_byte_t counterValue, compareA, compareB;
  logic ieB, ieA, overflow_irq_enable, trigEn, clkSelLow;
  evt_clr_t clearSel;
  evt_cks_t clkSel;
  evt_os_t osA, osB;
  evt_edge_t trigEdge;
  logic flagA, flagB, flagOvf, armA, armB, armOvf;
  logic running, ack, eqAPrev, eqBPrev;
  logic [2:0] syncA, syncB, syncEdge;
  logic [2:0] pinNow, pinPrev;
  evt_tick_if tickBus ();

  evt_prescaler u_prescaler (
    .core_clk(core_clk),
    .rst(rst),
    .ticks(tickBus.src)
  );

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic doWr, doRd, wrLow;
  logic wrCnt, wrCmpA, wrCmpB, wrCtl0, wrStat, wrCtl1;
  evt_byte_t wdata, next_readdata;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign doWr = avs_write & ack;
  assign doRd = avs_read & ~ack;
  assign wrLow = doWr & avs_byteenable[`EVT_B_BE0];
  assign wdata = avs_writedata[7:0];
  assign wrCnt = wrLow & (avs_address == `EVT_OFS_CNT);
  assign wrCmpA = wrLow & (avs_address == `EVT_OFS_CMPA);
  assign wrCmpB = wrLow & (avs_address == `EVT_OFS_CMPB);
  assign wrCtl0 = wrLow & (avs_address == `EVT_OFS_CTL0);
  assign wrStat = wrLow & (avs_address == `EVT_OFS_STAT);
  assign wrCtl1 = wrLow & (avs_address == `EVT_OFS_CTL1);

  always_comb begin
    case (avs_address)
      `EVT_OFS_CNT: next_readdata = counterValue;
      `EVT_OFS_CMPA: next_readdata = compareA;
      `EVT_OFS_CMPB: next_readdata = compareB;
      `EVT_OFS_CTL0: next_readdata = {ieB, ieA, overflow_irq_enable, clearSel, clkSel};
      `EVT_OFS_STAT: next_readdata = `EVT_STAT_ONES | {flagB, flagA, flagOvf, 1'b0, osB, osA};
      `EVT_OFS_CTL1: next_readdata = `EVT_CTL1_ONES | {3'h0, trigEdge, trigEn, 1'b0, clkSelLow};
      default: next_readdata = `EVT_CNT_RST;
    endcase
  end

  // One wait cycle; read data latched as the request is first seen
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack <= 1'b0;
      avs_readdata <= `EVT_RD_ZERO;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      if (doRd) begin
        avs_readdata <= {24'h000000, next_readdata};
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compareA <= `EVT_CMP_RST;
      compareB <= `EVT_CMP_RST;
      ieB <= 1'b0;
      ieA <= 1'b0;
      overflow_irq_enable <= 1'b0;
      clearSel <= EVT_CLR_NONE;
      clkSel <= EVT_CK_OFF0;
      osA <= EVT_OS_KEEP;
      osB <= EVT_OS_KEEP;
      trigEdge <= EVT_EDGE_OFF;
      trigEn <= 1'b0;
      clkSelLow <= 1'b0;
    end else begin
      if (wrCmpA) compareA <= wdata;
      if (wrCmpB) compareB <= wdata;
      if (wrCtl0) begin
        ieB <= wdata[`EVT_B_IEB];
        ieA <= wdata[`EVT_B_IEA];
        overflow_irq_enable <= wdata[`EVT_B_OVERFLOW_IRQ_ENABLE];
        clearSel <= evt_clr_t'(wdata[`EVT_F_CLR]);
        clkSel <= evt_cks_t'(wdata[`EVT_F_CKS]);
      end
      if (wrStat) begin
        osB <= evt_os_t'(wdata[`EVT_F_OSB]);
        osA <= evt_os_t'(wdata[`EVT_F_OSA]);
      end
      if (wrCtl1) begin
        trigEdge <= evt_edge_t'(wdata[`EVT_F_EDGE]);
        trigEn <= wdata[`EVT_B_TRIGGER_ENABLE];
        clkSelLow <= wdata[`EVT_B_ICKS];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  assign syncEdge = {trigger_pin, ext_clear_pin, ext_clock_pin};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      pinPrev <= 3'h0;
    end else begin
      syncA <= syncEdge;
      syncB <= syncA;
      pinPrev <= syncB;
    end
  end
  assign pinNow = syncB;

  logic extRise, extFall, clrRise, trigHit;
  assign extRise = pinNow[0] & ~pinPrev[0];
  assign extFall = ~pinNow[0] & pinPrev[0];
  assign clrRise = pinNow[1] & ~pinPrev[1];
  assign trigHit = edgeHit(trigEdge, pinNow[2] & ~pinPrev[2], ~pinNow[2] & pinPrev[2]);

  // ----------------------------------------------------------------
  // Count source
  // ----------------------------------------------------------------
  logic srcTick;
  logic [2:0] tapIdx;
  assign tapIdx = {clkSel[1:0] - 2'h1, clkSelLow};
  always_comb begin
    case (clkSel)
      EVT_CK_INT1, EVT_CK_INT2, EVT_CK_INT3: srcTick = tickBus.tick[tapIdx];
      EVT_CK_EXTR: srcTick = edgeHit(EVT_EDGE_RISE, extRise, extFall);
      EVT_CK_EXTF: srcTick = edgeHit(EVT_EDGE_FALL, extRise, extFall);
      EVT_CK_EXTB: srcTick = edgeHit(EVT_EDGE_BOTH, extRise, extFall);
      default: srcTick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Compare, clear and counter
  // ----------------------------------------------------------------
  logic eqA, eqB, matchA, matchB, clearEvt, countEn, ovfEvt;
  assign eqA = (counterValue == compareA) & ~wrCmpA;
  assign eqB = (counterValue == compareB) & ~wrCmpB;
  assign matchA = eqA & ~eqAPrev;
  assign matchB = eqB & ~eqBPrev;
  always_comb begin
    case (clearSel)
      EVT_CLR_A: clearEvt = matchA;
      EVT_CLR_B: clearEvt = matchB;
      EVT_CLR_PIN: clearEvt = clrRise;
      default: clearEvt = 1'b0;
    endcase
  end
  assign countEn = srcTick & (running | ~trigEn) & ~clearEvt;
  assign ovfEvt = countEn & ~wrCnt & (counterValue == `EVT_CNT_MAX);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      counterValue <= `EVT_CNT_RST;
      eqAPrev <= 1'b0;
      eqBPrev <= 1'b0;
    end else begin
      eqAPrev <= eqA;
      eqBPrev <= eqB;
      if (wrCnt) begin
        counterValue <= wdata;
      end else if (clearEvt) begin
        counterValue <= `EVT_CNT_RST;
      end else if (countEn) begin
        counterValue <= counterValue + 8'h01;
      end
    end
  end

  // Trigger start; halt on clear while trigger mode is on
  always_ff @(posedge core_clk) begin
    if (rst) begin
      running <= 1'b0;
    end else if (trigEn & trigHit) begin
      running <= 1'b1;
    end else if (trigEn & clearEvt) begin
      running <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flags, read-then-write-zero clear
  // ----------------------------------------------------------------
  logic rdStat;
  assign rdStat = doRd & (avs_address == `EVT_OFS_STAT);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flagA <= 1'b0;
      flagB <= 1'b0;
      flagOvf <= 1'b0;
      armA <= 1'b0;
      armB <= 1'b0;
      armOvf <= 1'b0;
    end else begin
      if (rdStat) begin
        armA <= flagA;
        armB <= flagB;
        armOvf <= flagOvf;
      end else if (wrStat) begin
        armA <= 1'b0;
        armB <= 1'b0;
        armOvf <= 1'b0;
      end
      // Set wins over a clear in the same cycle
      flagA <= matchA | (flagA & ~(wrStat & armA & ~wdata[`EVT_B_FA]));
      flagB <= matchB | (flagB & ~(wrStat & armB & ~wdata[`EVT_B_FB]));
      flagOvf <= ovfEvt | (flagOvf & ~(wrStat & armOvf & ~wdata[`EVT_B_OVF]));
    end
  end

  // ----------------------------------------------------------------
  // Requests and wave output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      matchAIrq <= 1'b0;
      matchBIrq <= 1'b0;
      overflowIrq <= 1'b0;
    end else begin
      matchAIrq <= flagA & ieA;
      matchBIrq <= flagB & ieB;
      overflowIrq <= flagOvf & overflow_irq_enable;
    end
  end

  // Match B is applied after match A when both hit together
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wave_out_pin <= 1'b0;
    end else if (matchB) begin
      wave_out_pin <= applyOs(osB, matchA ? applyOs(osA, wave_out_pin) : wave_out_pin);
    end else if (matchA) begin
      wave_out_pin <= applyOs(osA, wave_out_pin);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence sReadFlagA;
    rdStat && flagA;
  endsequence
  sequence sTrigStart;
    trigEn && trigHit && !rst;
  endsequence

  chk_reset_values: assert property (disable iff (1'b0) rst |=>
    counterValue == `EVT_CNT_RST && compareA == `EVT_CMP_RST && !wave_out_pin)
    else $error("reset values wrong");
  chk_overflow_flag: assert property (ovfEvt |=> flagOvf && counterValue == `EVT_CNT_RST)
    else $error("overflow flag not set");
  chk_match_flag: assert property (matchA |=> flagA)
    else $error("match A flag not set");
  chk_write_suppress: assert property (wrCmpB && !flagB |=> !flagB)
    else $error("compare during compare write");
  chk_irq_gate: assert property (flagB && ieB |=> matchBIrq)
    else $error("match B request missing");
  chk_clear_match: assert property (clearSel == EVT_CLR_A && matchA && !wrCnt |=>
    counterValue == `EVT_CNT_RST) else $error("clear on match A missing");
  chk_stop_select: assert property (clkSel[1:0] == 2'h0 && !wrCnt && !clearEvt |=>
    counterValue == $past(counterValue)) else $error("counter moved while stopped");
  chk_wave_toggle: assert property (matchA && !matchB && osA == EVT_OS_TOG |=>
    wave_out_pin != $past(wave_out_pin)) else $error("wave toggle missing");
  chk_flag_clear: assert property ($fell(flagA) |-> $past(armA))
    else $error("flag cleared without read");
  chk_trig_start: assert property (sTrigStart |=> running)
    else $error("trigger did not start");
  chk_write_wins: assert property (wrCnt |=> counterValue == $past(wdata))
    else $error("counter write lost");
  chk_read_arm: assert property (sReadFlagA ##1 !matchA[*2] |-> ##0 armA)
    else $error("read did not arm clear");
  chk_bus_answer: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("bus answer late");
endmodule // evt_timer

// File: testbench/evt_pin_model.sv
// Pin partner of the event timer: external clock, clear and trigger pins
// Assumes the bench calls its tasks from one process, pins idle low
`timescale 1ns/100ps
module evt_pin_model (
  input wire logic core_clk,
  output logic ext_clock_pin,
  output logic ext_clear_pin,
  output logic trigger_pin
);
  initial begin
    ext_clock_pin = 1'b0;
    ext_clear_pin = 1'b0;
    trigger_pin = 1'b0;
  end

  // Four clocks per level, wide enough for the pin synchroniser
  task automatic clock_pulses(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ext_clock_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      ext_clock_pin <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask

  task automatic clear_pulse();
    @(posedge core_clk);
    ext_clear_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    ext_clear_pin <= 1'b0;
  endtask

  task automatic trigger_pulse();
    @(posedge core_clk);
    trigger_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    trigger_pin <= 1'b0;
  endtask
endmodule // evt_pin_model

// File: testbench/tb.sv
// Self-checking bench of the event timer over Avalon-MM and its pins
// Assumes the design files and the pin model are compiled before it
`timescale 1ns/100ps
`include "evt_consts.svh"
module tb;
  import evt_pkg::*;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  localparam int LIMIT = 20000;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  evt_addr_t avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  evt_word_t avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h0;
  evt_word_t avs_readdata;
  logic avs_waitrequest, ext_clock_pin, ext_clear_pin, trigger_pin, wave_out_pin;
  logic matchAIrq, matchBIrq, overflowIrq;
  int failures = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int seed = 32'ha035f813;

  always #12.5 core_clk = ~core_clk;

  evt_timer uut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_clock_pin(ext_clock_pin),
    .ext_clear_pin(ext_clear_pin), .trigger_pin(trigger_pin),
    .wave_out_pin(wave_out_pin), .matchAIrq(matchAIrq), .matchBIrq(matchBIrq),
    .overflowIrq(overflowIrq));

  evt_pin_model pins (.core_clk(core_clk), .ext_clock_pin(ext_clock_pin),
    .ext_clear_pin(ext_clear_pin), .trigger_pin(trigger_pin));

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      $display("wrong value at %0t: run timed out", $time);
      end_of_test();
    end
  end

  task automatic fail(input string msg);
    failures++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  task automatic check_byte(input evt_byte_t got, input evt_byte_t exp, input string msg);
    samplesChecked++;
    if (got !== exp) fail(msg);
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    samplesChecked++;
    if (got !== exp) fail(msg);
  endtask

  task automatic check_range(input logic [15:0] got, input int lo, input int hi, input string msg);
    samplesChecked++;
    if ($isunknown(got) || got < lo || got > hi) fail(msg);
  endtask

  task automatic bus(input evt_addr_t a, input logic wr, input evt_byte_t d, output evt_byte_t q);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= 4'hf;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input evt_addr_t a, input evt_byte_t d);
    evt_byte_t q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd(input evt_addr_t a, output evt_byte_t q);
    bus(a, 1'b0, 8'h00, q);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic test_done(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  function automatic logic wave_after(input int os, input logic prev);
    case (os)
      0: return prev;
      1: return 1'b0;
      2: return 1'b1;
      default: return ~prev;
    endcase
  endfunction

  function automatic int ticks_for(input int i);
    return (i == 0 || i == 7) ? 0 : 256 >> i;
  endfunction

  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    evt_byte_t q, v;
    logic w;
    int n, exp, hi;
    idle(2);
    rst <= 1'b0;
    idle(1);
    rd(`EVT_OFS_CNT, q);
    check_byte(q, `EVT_CNT_RST, "counter reset");
    rd(`EVT_OFS_CMPA, q);
    check_byte(q, `EVT_CMP_RST, "compare A reset");
    rd(`EVT_OFS_CMPB, q);
    check_byte(q, `EVT_CMP_RST, "compare B reset");
    rd(`EVT_OFS_CTL0, q);
    check_byte(q, 8'h00, "control zero reset");
    rd(`EVT_OFS_STAT, q);
    check_byte(q, `EVT_STAT_ONES, "status reset");
    rd(`EVT_OFS_CTL1, q);
    check_byte(q, `EVT_CTL1_ONES, "control one reset");
    rd(5'h18, q);
    check_byte(q, 8'h00, "unmapped read");
    check_bit(wave_out_pin, 1'b0, "wave after reset");
    test_done("reset");

    wr(`EVT_OFS_CTL0, 8'h01);
    v = 8'($random(seed)) & 8'h7f;
    wr(`EVT_OFS_CNT, v);
    rd(`EVT_OFS_CNT, q);
    check_range({8'h00, q}, v, v + 1, "counter write while counting");
    wr(`EVT_OFS_CTL0, 8'h00);
    v = 8'($random(seed));
    wr(`EVT_OFS_CMPB, v);
    rd(`EVT_OFS_CMPB, q);
    check_byte(q, v, "compare B readback");
    test_done("access");

    for (int i = 0; i < 8; i++) begin
      wr(`EVT_OFS_CTL0, 8'h00);
      wr(`EVT_OFS_CNT, 8'h00);
      wr(`EVT_OFS_CTL1, (i == 0 || i == 7) ? 8'h01 : 8'((i + 1) % 2));
      wr(`EVT_OFS_CTL0, (i == 0) ? 8'h00 : (i == 7) ? 8'h04 : 8'((i + 1) / 2));
      idle(510);
      rd(`EVT_OFS_CNT, q);
      exp = ticks_for(i);
      check_range({8'h00, q}, exp == 0 ? 0 : exp - 1, exp == 0 ? 0 : exp + 1, "rate");
    end
    test_done("internal sources");

    for (int i = 0; i < 4; i++) begin
      n = 1 + ($random(seed) & 3);
      exp = (i == 2) ? 2 * n : n;
      wr(`EVT_OFS_CTL0, 8'h00);
      wr(`EVT_OFS_CNT, 8'h00);
      wr(`EVT_OFS_CMPA, 8'(exp));
      wr(`EVT_OFS_STAT, 8'(i));
      wr(`EVT_OFS_CTL0, 8'(5 + i % 3));
      w = wave_out_pin;
      pins.clock_pulses(n);
      idle(8);
      rd(`EVT_OFS_CNT, q);
      check_byte(q, 8'(exp), "external edge count");
      check_bit(wave_out_pin, wave_after(i, w), "wave action");
    end
    test_done("external source");

    v = 8'(16 + ($random(seed) & 15));
    wr(`EVT_OFS_CTL0, 8'h00);
    wr(`EVT_OFS_CNT, 8'h00);
    wr(`EVT_OFS_CMPA, v);
    wr(`EVT_OFS_CMPB, 8'd100);
    wr(`EVT_OFS_STAT, 8'h06);
    wr(`EVT_OFS_CTL0, 8'hd1);
    idle(500);
    hi = 0;
    repeat (1600) begin
      @(posedge core_clk);
      if (wave_out_pin === 1'b1) hi++;
    end
    exp = 16 * (100 - v);
    check_range(16'(hi), exp - 8, exp + 8, "pwm duty");
    rd(`EVT_OFS_CNT, q);
    check_range({8'h00, q}, 0, 100, "clear on match B");
    check_bit(matchAIrq, 1'b1, "irq A");
    check_bit(matchBIrq, 1'b1, "irq B");
    check_bit(overflowIrq, 1'b0, "irq overflow idle");
    test_done("pwm");

    wr(`EVT_OFS_CTL0, 8'h00);
    wr(`EVT_OFS_CNT, 8'hfe);
    wr(`EVT_OFS_CTL0, 8'h21);
    idle(20);
    wr(`EVT_OFS_CTL0, 8'h20);
    check_bit(overflowIrq, 1'b1, "overflow irq");
    wr(`EVT_OFS_STAT, 8'h00);
    rd(`EVT_OFS_STAT, q);
    check_bit(q[5], 1'b1, "flag kept without read");
    wr(`EVT_OFS_STAT, 8'h00);
    rd(`EVT_OFS_STAT, q);
    check_bit(q[5], 1'b0, "flag cleared");
    idle(2);
    check_bit(overflowIrq, 1'b0, "overflow irq gone");
    test_done("overflow");

    wr(`EVT_OFS_CNT, 8'h00);
    wr(`EVT_OFS_CMPA, 8'h05);
    wr(`EVT_OFS_CTL1, 8'h0c);
    wr(`EVT_OFS_CTL0, 8'h09);
    idle(40);
    rd(`EVT_OFS_CNT, q);
    check_byte(q, 8'h00, "idle before trigger");
    pins.trigger_pulse();
    idle(60);
    rd(`EVT_OFS_CNT, q);
    check_byte(q, 8'h00, "halt after clear");
    rd(`EVT_OFS_STAT, q);
    check_bit(q[6], 1'b1, "match after trigger");
    wr(`EVT_OFS_CTL1, 8'h00);
    wr(`EVT_OFS_CTL0, 8'h19);
    idle(200);
    pins.clear_pulse();
    rd(`EVT_OFS_CNT, q);
    check_range({8'h00, q}, 0, 4, "pin clear");
    wr(`EVT_OFS_CTL1, 8'h1c);
    pins.trigger_pulse();
    idle(40);
    pins.clear_pulse();
    idle(40);
    rd(`EVT_OFS_CNT, q);
    check_byte(q, 8'h00, "halt after pin clear");
    test_done("trigger");
    end_of_test();
  end
endmodule // tb
